/* File: rtl/flash_ctl_params.svh */
// constants for the flash program/erase controller: offsets, fields, codes, timing
`ifndef FLASH_CTL_PARAMS_SVH
`define FLASH_CTL_PARAMS_SVH
// register byte offsets (low 16 address bits)
`define OFS_CONTROL   16'hF400
`define OFS_KEY       16'hF410
`define OFS_ADDR      16'hF420
`define OFS_DATA      16'hF430
`define OFS_SRC       16'hF440
`define OFS_IRQ_STAT  16'hF450
`define OFS_IRQ_EN    16'hF454
`define OFS_IRQ_CLR   16'hF458
// control register field positions
`define BIT_GO        15
`define BIT_PROG_WRITE_ENABLE      14
`define BIT_FAIL      13
`define BIT_LVERR     12
`define BIT_LVLIVE    11
// operation codes
`define OP_NONE       4'h0
`define OP_WORD       4'h1
`define OP_ROW        4'h3
`define OP_PAGE       4'h4
`define OP_ARRAY      4'h5
// unlock keys, written back to back
`define KEY_FIRST     32'hAA996655
`define KEY_SECOND    32'h556699AA
// sizes in bytes
`define PAGE_BYTES    1024
`define ROW_BYTES     128
// operation times in ns
`define T_WORD_NS     2000
`define T_ROW_NS      8000
`define T_ERASE_NS    16000
`define CLK_NS        4
`endif

/* File: rtl/flash_ctl_pkg.sv */
// types shared by the flash program/erase controller
package flash_ctl_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_BUSY = 2'b01,
		ST_DONE = 2'b10
	} seq_state_t;
	typedef enum logic [1:0] {
		UNL_NONE  = 2'b00,
		UNL_FIRST = 2'b01,
		UNL_READY = 2'b10
	} unlock_state_t;
endpackage

/* File: rtl/flash_program_erase_control.sv */
// flash program/erase sequencer with apb register slave and event interrupt
// What this block does
// - go bit starts operation, hardware clears it
// - go accepted only armed and just unlocked
// - device reset clears only write enable among the control bits
// - write enable gates go and detector
// - fail flag set when sequence fails
// - low voltage error flag when detector trips
// - live low voltage bit follows detector
// - operation select writable only unarmed
// - code 0101 erases array unless protected
// - code 0100 erases addressed page unless protected
// - code 0011 programs addressed row unless protected
// - code 0001 programs addressed word unless protected
// - page 1 KB, row 128 bytes aligned
// - upper and unused control bits read zero
// - flags cleared by starting code zero
// - unlock key is write-only, reads zero
// - program word cleared only at power-on
`timescale 1ns/10ps
`include "flash_ctl_params.svh"
module flash_program_erase_control #(
	parameter int ADDR_W     = 32,                                        // flash address width
	parameter int T_WORD_CYC = (`T_WORD_NS + `CLK_NS - 1) / `CLK_NS,      // word program time
	parameter int T_ROW_CYC  = (`T_ROW_NS + `CLK_NS - 1) / `CLK_NS,       // row program time
	parameter int T_ERASE_CYC = (`T_ERASE_NS + `CLK_NS - 1) / `CLK_NS     // erase time
) (
	input  wire logic               CLK,          // system clock, 250 MHz
	input  wire logic               RST_B,        // device reset, async, active low
	input  wire logic               POR_B,        // power-on reset, async, active low
	input  wire logic               PSEL,
	input  wire logic               PENABLE,
	input  wire logic               PWRITE,
	input  wire logic [31:0]        PADDR,
	input  wire logic [31:0]        PWDATA,
	output logic      [31:0]        PRDATA,
	output logic                    PREADY,
	output logic                    PSLVERR,
	input  wire logic               LOW_VOLT_DETECT,  // raw detector comparator output
	output logic                    DETECTOR_ENABLE,  // powers the low_voltage_detector
	input  wire logic               PROTECT_HIT,      // target region write-protected
	input  wire logic               ARRAY_PROTECTED,  // some page of the array protected
	output logic                    FLASH_START,      // one-cycle start of an array operation
	output logic      [3:0]         FLASH_OP,         // operation being run
	output logic      [ADDR_W-1:0]  FLASH_ADDR,       // aligned target address
	output logic      [31:0]        FLASH_WDATA,      // word to program
	output logic      [31:0]        FLASH_SRC,        // row source address
	output logic                    IRQ               // level interrupt
);

	////////////////////////////////////////////////////////////////////////////////
	// register state

	logic                       go;              // operation running
	logic                       prog_write_enable;
	logic                       prog_fail_flag;
	logic                       low_volt_fail_flag;
	logic [3:0]                 operation_select;
	logic [31:0]                target_address;
	logic [31:0]                program_word;
	logic [31:0]                row_source_address;
	logic [2:0]                 irq_stat;        // done, fail, low voltage
	logic [2:0]                 irq_en;
	logic [31:0]                rdata;           // registered read data
	flash_ctl_pkg::seq_state_t    state;
	flash_ctl_pkg::unlock_state_t unlock;
	logic [31:0]                timer;           // operation cycle count
	logic                       low_volt_live;

	// note on the address map: only the low sixteen address bits are decoded,
	// so the block repeats through any larger window that the bus fabric gives it.
	// the control word sits below the key register; the interrupt trio sits above
	// the source register. words only: there are no byte strobes, and a part-word
	// store from software lands as a whole word.
	// every register answers with no wait state, so a bus master never stalls here.

	////////////////////////////////////////////////////////////////////////////////
	// bus decode

	// true when the access hits the given offset
	function automatic logic hit(input logic [31:0] a, input logic [15:0] ofs);
		hit = (a[15:0] == ofs);
	endfunction

	wire        access     = PSEL & PENABLE;            // access phase, always ready
	wire        wr         = access & PWRITE;
	wire        rd         = access & ~PWRITE;
	wire        wr_ctl     = wr & hit(PADDR, `OFS_CONTROL);
	wire        wr_key     = wr & hit(PADDR, `OFS_KEY);
	wire        mapped     = hit(PADDR, `OFS_CONTROL) | hit(PADDR, `OFS_KEY) | hit(PADDR, `OFS_ADDR)
	                       | hit(PADDR, `OFS_DATA) | hit(PADDR, `OFS_SRC) | hit(PADDR, `OFS_IRQ_STAT)
	                       | hit(PADDR, `OFS_IRQ_EN) | hit(PADDR, `OFS_IRQ_CLR);
	// go only taken while armed and straight after the key pair
	wire        go_req     = wr_ctl & PWDATA[`BIT_GO] & prog_write_enable
	                       & (unlock == flash_ctl_pkg::UNL_READY) & ~go;
	// operation select only moves while disarmed
	wire        opsel_wr   = wr_ctl & ~prog_write_enable;
	wire [3:0]  op         = operation_select;
	// codes that really touch the array
	wire        op_real    = (op == `OP_WORD) | (op == `OP_ROW) | (op == `OP_PAGE) | (op == `OP_ARRAY);
	wire        protected_op = (op == `OP_ARRAY) ? ARRAY_PROTECTED : PROTECT_HIT;
	wire [31:0] op_cycles  = (op == `OP_WORD) ? 32'(T_WORD_CYC) :
	                         (op == `OP_ROW)  ? 32'(T_ROW_CYC)  : 32'(T_ERASE_CYC);
	wire        op_end     = (state == flash_ctl_pkg::ST_BUSY) & (timer == 32'h00000000);

	// alignment of the address to the chosen granularity
	wire [31:0] page_mask  = ~(32'(`PAGE_BYTES) - 32'h00000001);
	wire [31:0] row_mask   = ~(32'(`ROW_BYTES) - 32'h00000001);
	wire [31:0] aligned_addr = (op == `OP_PAGE) ? (target_address & page_mask) :
	                           (op == `OP_ROW)  ? (target_address & row_mask)  :
	                           (op == `OP_ARRAY) ? 32'h00000000 : (target_address & 32'hFFFFFFFC);

	// control register image; upper half and gaps are zero
	wire [31:0] ctl_image  = {16'h0000, go, prog_write_enable, prog_fail_flag, low_volt_fail_flag,
	                          low_volt_live, 7'h00, operation_select};

	// read mux; key register always reads zero
	// the keys are never stored, only matched, so a read can not leak them;
	// unmapped offsets read zero and raise the slave error in the access phase
	wire [31:0] next_rdata = hit(PADDR, `OFS_CONTROL)  ? ctl_image :
	                         hit(PADDR, `OFS_KEY)      ? 32'h00000000 :
	                         hit(PADDR, `OFS_ADDR)     ? target_address :
	                         hit(PADDR, `OFS_DATA)     ? program_word :
	                         hit(PADDR, `OFS_SRC)      ? row_source_address :
	                         hit(PADDR, `OFS_IRQ_STAT) ? {29'h00000000, irq_stat} :
	                         hit(PADDR, `OFS_IRQ_EN)   ? {29'h00000000, irq_en} : 32'h00000000;

	assign PREADY  = 1'b1;                  // zero wait states
	assign PSLVERR = access & ~mapped;      // unmapped offsets error
	assign PRDATA  = rdata;

	// read data in the access cycle is the flop output, not the mux, registered
	// for the data-out style; the flop follows the mux in the setup cycle
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			rdata <= 32'h00000000;
		end else if (PSEL & ~PENABLE & ~PWRITE) begin
			rdata <= next_rdata;
		end else if (rd) begin
			rdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// unlock tracker: two keys in successive accesses, then the go write
	// any access at all, read or write, to any offset steps the tracker, so an
	// interrupt handler that touches the block between the keys and the go write
	// voids the unlock; software must keep that stretch free of interruption.
	// a wrong second key drops back to idle rather than waiting for a retry.

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			unlock <= flash_ctl_pkg::UNL_NONE;
		end else if (access) begin
			// any access that is not the next expected step voids the unlock
			if (wr_key && PWDATA == `KEY_FIRST) begin
				unlock <= flash_ctl_pkg::UNL_FIRST;
			end else if (wr_key && PWDATA == `KEY_SECOND && unlock == flash_ctl_pkg::UNL_FIRST) begin
				unlock <= flash_ctl_pkg::UNL_READY;
			end else begin
				unlock <= flash_ctl_pkg::UNL_NONE;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// write enable: the only control bit cleared by device reset
	// every control write reloads it, so software must keep bit 14 set in the go
	// write; a device reset during a running operation leaves go and the timer alone

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			prog_write_enable <= 1'b0;
		end else if (wr_ctl) begin
			prog_write_enable <= PWDATA[`BIT_PROG_WRITE_ENABLE];
		end
	end

	assign DETECTOR_ENABLE = prog_write_enable;
	assign low_volt_live   = prog_write_enable & LOW_VOLT_DETECT;

	////////////////////////////////////////////////////////////////////////////////
	// power-on-only control state, sequencer and data registers
	// these survive a device reset so software can inspect a failed operation

	always_ff @(posedge CLK or negedge POR_B) begin
		if (!POR_B) begin
			go                 <= 1'b0;
			operation_select   <= `OP_NONE;
			prog_fail_flag     <= 1'b0;
			low_volt_fail_flag <= 1'b0;
			program_word       <= 32'h00000000;
			target_address     <= 32'h00000000;
			row_source_address <= 32'h00000000;
			state              <= flash_ctl_pkg::ST_IDLE;
			timer              <= 32'h00000000;
		end else begin
			if (opsel_wr) begin
				operation_select <= PWDATA[3:0];
			end
			if (wr & hit(PADDR, `OFS_ADDR)) begin
				target_address <= PWDATA;
			end
			if (wr & hit(PADDR, `OFS_DATA)) begin
				program_word <= PWDATA;
			end
			if (wr & hit(PADDR, `OFS_SRC)) begin
				row_source_address <= PWDATA;
			end
			// detector trip while armed latches the error
			if (low_volt_live) begin
				low_volt_fail_flag <= 1'b1;
			end
			// sequencer: idle waits for an accepted go, busy counts the operation
			// time down, done spends one cycle clearing go. protection and unknown
			// codes skip busy entirely, so the array never sees a start for them.
			// the fail flag is rewritten at every accepted go, so it always tells the
			// result of the latest operation; the low voltage error latches until a code-zero go clears it with the detector quiet.
			unique case (state)
				flash_ctl_pkg::ST_IDLE: begin
					if (go_req) begin
						go <= 1'b1;
						if (op == `OP_NONE) begin
							// code zero clears the error flags
							prog_fail_flag <= 1'b0;
							if (!low_volt_live) begin
								low_volt_fail_flag <= 1'b0;
							end
							state <= flash_ctl_pkg::ST_DONE;
						end else if (!op_real || protected_op) begin
							// nothing touches the array; protection counts as failure
							prog_fail_flag <= protected_op & op_real;
							state <= flash_ctl_pkg::ST_DONE;
						end else begin
							prog_fail_flag <= 1'b0;
							timer <= op_cycles - 32'h00000001;
							state <= flash_ctl_pkg::ST_BUSY;
						end
					end
				end
				flash_ctl_pkg::ST_BUSY: begin
					if (low_volt_live) begin
						prog_fail_flag <= 1'b1;
					end
					if (op_end) begin
						state <= flash_ctl_pkg::ST_DONE;
					end else begin
						timer <= timer - 32'h00000001;
					end
				end
				flash_ctl_pkg::ST_DONE: begin
					go    <= 1'b0;
					state <= flash_ctl_pkg::ST_IDLE;
				end
				default: begin
					state <= flash_ctl_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// start pulse toward the array only for real, unprotected codes
	assign FLASH_START = go_req & (state == flash_ctl_pkg::ST_IDLE) & op_real & ~protected_op;
	assign FLASH_OP    = operation_select;
	assign FLASH_ADDR  = aligned_addr[ADDR_W-1:0];
	assign FLASH_WDATA = program_word;
	assign FLASH_SRC   = row_source_address;

	////////////////////////////////////////////////////////////////////////////////
	// interrupt status: done, fail, low voltage; set wins over clear
	// an event in the same cycle as its clear stays pending, so no completion is
	// lost; the cost is that software may see one extra interrupt after clearing.
	// the status bits clear on device reset, unlike the flags in the control word.

	wire [2:0] irq_evt   = {low_volt_live & ~low_volt_fail_flag,
	                        op_end & low_volt_live,
	                        state == flash_ctl_pkg::ST_DONE};
	wire [2:0] irq_clr   = (wr & hit(PADDR, `OFS_IRQ_CLR)) ? PWDATA[2:0] : 3'h0;

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			irq_stat <= 3'h0;
			irq_en   <= 3'h0;
		end else begin
			irq_stat <= (irq_stat & ~irq_clr) | irq_evt;
			if (wr & hit(PADDR, `OFS_IRQ_EN)) begin
				irq_en <= PWDATA[2:0];
			end
		end
	end

	assign IRQ = |(irq_stat & irq_en);

	////////////////////////////////////////////////////////////////////////////////
	// checks
	// all of them are off while either reset is low; the busy counter below is
	// helper logic for the timing check only and drives nothing outside

	// cycles spent busy, cleared whenever the sequencer leaves busy
	logic [31:0] busy_len;

	always_ff @(posedge CLK or negedge POR_B) begin
		if (!POR_B) begin
			busy_len <= 32'h00000000;
		end else if (state == flash_ctl_pkg::ST_BUSY) begin
			busy_len <= busy_len + 32'h00000001;
		end else begin
			busy_len <= 32'h00000000;
		end
	end

	go_clears_a: assert property (@(posedge CLK) disable iff (!RST_B || !POR_B)
		state == flash_ctl_pkg::ST_DONE |=> !go)
		else $error("go bit not cleared after operation");
	go_gated_a: assert property (@(posedge CLK) disable iff (!RST_B || !POR_B)
		$rose(go) |-> $past(prog_write_enable) && $past(unlock) == flash_ctl_pkg::UNL_READY)
		else $error("go set without arm and unlock");
	detector_a: assert property (@(posedge CLK) disable iff (!RST_B || !POR_B)
		DETECTOR_ENABLE == prog_write_enable)
		else $error("detector enable mismatch");
	live_bit_a: assert property (@(posedge CLK) disable iff (!RST_B || !POR_B)
		ctl_image[`BIT_LVLIVE] == (prog_write_enable && LOW_VOLT_DETECT))
		else $error("live low voltage bit wrong");
	lv_error_a: assert property (@(posedge CLK) disable iff (!RST_B || !POR_B)
		low_volt_live |=> low_volt_fail_flag)
		else $error("low voltage error not latched");
	opsel_hold_a: assert property (@(posedge CLK) disable iff (!RST_B || !POR_B)
		prog_write_enable |=> $stable(operation_select))
		else $error("operation select moved while armed");
	upper_zero_a: assert property (@(posedge CLK) disable iff (!RST_B || !POR_B)
		ctl_image[31:16] == 16'h0000 && ctl_image[10:4] == 7'h00)
		else $error("unused control bits not zero");
	// busy lasts exactly the chosen operation time
	busy_time_a: assert property (@(posedge CLK) disable iff (!RST_B || !POR_B)
		op_end |-> busy_len == op_cycles - 32'h00000001)
		else $error("operation time wrong");
	// a start always leads into busy with go set
	start_busy_a: assert property (@(posedge CLK) disable iff (!RST_B || !POR_B)
		FLASH_START |=> go && state == flash_ctl_pkg::ST_BUSY)
		else $error("start did not enter busy");
	// go stands for the whole operation
	go_hold_a: assert property (@(posedge CLK) disable iff (!RST_B || !POR_B)
		go && state == flash_ctl_pkg::ST_BUSY |=> go)
		else $error("go dropped while busy");
	// key offset never returns data
	key_zero_a: assert property (@(posedge CLK) disable iff (!RST_B || !POR_B)
		hit(PADDR, `OFS_KEY) |-> next_rdata == 32'h00000000)
		else $error("key register read not zero");
	// detector trip during busy marks the operation failed
	fail_busy_a: assert property (@(posedge CLK) disable iff (!RST_B || !POR_B)
		state == flash_ctl_pkg::ST_BUSY && low_volt_live |=> prog_fail_flag)
		else $error("fail flag not set on low voltage");
	// protected target: no start, fail flag next
	protect_fail_a: assert property (@(posedge CLK) disable iff (!RST_B || !POR_B)
		go_req && op_real && protected_op |-> !FLASH_START ##1 prog_fail_flag)
		else $error("protected operation not refused");
	// code zero with go clears the fail flag
	flag_clear_a: assert property (@(posedge CLK) disable iff (!RST_B || !POR_B)
		go_req && op == `OP_NONE |=> !prog_fail_flag)
		else $error("fail flag not cleared by code zero");
	// row and page addresses land on their boundaries
	addr_align_a: assert property (@(posedge CLK) disable iff (!RST_B || !POR_B)
		(op == `OP_ROW |-> (aligned_addr & ~row_mask) == 32'h00000000)
		and (op == `OP_PAGE |-> (aligned_addr & ~page_mask) == 32'h00000000))
		else $error("target address not aligned");
	// whole-array erase ignores the target address
	array_addr_a: assert property (@(posedge CLK) disable iff (!RST_B || !POR_B)
		op == `OP_ARRAY |-> aligned_addr == 32'h00000000)
		else $error("array erase address not zero");
	nop_quiet_a: assert property (@(posedge CLK) disable iff (!RST_B || !POR_B)
		go_req && !op_real |-> !FLASH_START)
		else $error("start pulse for a no-op code");

endmodule

/* File: testbench/flash_program_erase_control_tb.sv */
// self-checking bench for the flash program/erase controller over apb
`timescale 1ns/10ps
`include "flash_ctl_params.svh"
module flash_program_erase_control_tb;
	localparam logic [31:0] A = 32'h0003A5FE;          // deliberately unaligned target
	logic        clk     = 1'b0;                        // 250 MHz system clock
	logic        rst_b   = 1'b0;                        // device reset
	logic        por_b   = 1'b0;                        // power-on reset
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [31:0] paddr   = 32'h00000000;
	logic [31:0] pwdata  = 32'h00000000;
	logic        low_voltage_detector     = 1'b0;                        // detector comparator
	logic        prot    = 1'b0;                        // target protected
	logic        aprot   = 1'b0;                        // some page protected
	wire  [31:0] prdata, f_addr, f_wdata, f_src;
	wire         pready, pslverr, det_en, f_start, irq;
	wire  [3:0]  f_op;
	int          mismatches      = 0;
	int          samples_checked = 0;
	int          starts          = 0;                   // array starts seen
	logic [31:0] rd;                                    // last read data
	logic [31:0] st_addr;                               // address at last start
	logic [3:0]  st_op;                                 // code at last start
	logic        err;                                   // last slave error
	logic [3:0]  ops [4] = '{4'h1, 4'h3, 4'h4, 4'h5};
	logic [31:0] msk [4] = '{32'hFFFFFFFC, 32'hFFFFFF80, 32'hFFFFFC00, 32'h00000000};

	// short operation times keep the run brief
	flash_program_erase_control #(.T_WORD_CYC(4), .T_ROW_CYC(4), .T_ERASE_CYC(4)) dut (
		.CLK(clk), .RST_B(rst_b), .POR_B(por_b), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .LOW_VOLT_DETECT(low_voltage_detector), .DETECTOR_ENABLE(det_en), .PROTECT_HIT(prot),
		.ARRAY_PROTECTED(aprot), .FLASH_START(f_start), .FLASH_OP(f_op), .FLASH_ADDR(f_addr),
		.FLASH_WDATA(f_wdata), .FLASH_SRC(f_src), .IRQ(irq));

	////////////////////////////////////////////////////////////////////////////////
	// clock, and start monitor sampled mid-cycle since the pulse is combinational
	always #2 clk = ~clk;
	always @(negedge clk) begin
		if (f_start === 1'b1) begin
			starts++;
			st_op = f_op;
			st_addr = f_addr;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// verdict, comparison and bus tasks
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// one apb transfer; answer taken at the rising edge where pready is seen high
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		int   n;
		logic rdy;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {16'h0000, a};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			rdy = pready;
			rd = prdata;
			err = pslverr;
		end while (rdy !== 1'b1 && n < 50);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
		if (rdy !== 1'b1) begin
			chk(1'b0, 1'b1, "no bus answer");
			final_report();
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [15:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h00000000);
		chk(rd, exp, what);
	endtask
	// choose code unarmed, arm, unlock, go; then poll until go clears (bounded)
	task automatic run_op(input logic [3:0] op, input logic busy, input int exp_starts);
		int s;
		int n;
		s = starts;
		n = 0;
		wr(`OFS_CONTROL, {28'h0000000, op});
		wr(`OFS_CONTROL, 32'h00004000 | op);
		wr(`OFS_KEY, `KEY_FIRST);
		wr(`OFS_KEY, `KEY_SECOND);
		wr(`OFS_CONTROL, 32'h0000C000 | op);
		apb(1'b0, `OFS_CONTROL, 32'h00000000);
		if (busy)
			chk(rd[15], 1'b1, "go while busy");
		while (rd[15] !== 1'b0 && n < 40) begin
			apb(1'b0, `OFS_CONTROL, 32'h00000000);
			n++;
		end
		chk(rd[15], 1'b0, "go cleared");
		if (rd[15] !== 1'b0)
			final_report();
		chk(starts - s, exp_starts, "start count");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		por_b <= 1'b1;
		@(posedge clk);
		rdc(`OFS_CONTROL, 32'h00000000, "control reset");
		wr(`OFS_ADDR, A);
		wr(`OFS_DATA, 32'hA5A5A5A5);
		wr(`OFS_SRC, 32'h00001000);
		wr(`OFS_KEY, `KEY_FIRST);
		rdc(`OFS_KEY, 32'h00000000, "key read");
		rdc(`OFS_DATA, 32'hA5A5A5A5, "data read");
		rdc(`OFS_SRC, 32'h00001000, "source read");
		wr(`OFS_CONTROL, 32'hFFFF07F2);
		rdc(`OFS_CONTROL, 32'h00000002, "unused bits");
		apb(1'b0, 16'hF408, 32'h00000000);
		chk(err, 1'b1, "unmapped error");
		$display("test registers done");
		// every program and erase code, with its address alignment
		foreach (ops[i]) begin
			run_op(ops[i], 1'b1, 1);
			chk(st_op, ops[i], "start code");
			chk(st_addr, A & msk[i], "start address");
			rdc(`OFS_CONTROL, 32'h00004000 | ops[i], "no flags");
			chk(det_en, 1'b1, "detector on");
		end
		$display("test operations done");
		// code locked while armed; go refused without or after a broken unlock
		wr(`OFS_CONTROL, 32'h00004001);
		rdc(`OFS_CONTROL, 32'h00004005, "code locked");
		wr(`OFS_CONTROL, 32'h0000C005);
		rdc(`OFS_CONTROL, 32'h00004005, "go without unlock");
		wr(`OFS_KEY, `KEY_FIRST);
		wr(`OFS_KEY, `KEY_SECOND);
		apb(1'b0, `OFS_ADDR, 32'h00000000);
		wr(`OFS_CONTROL, 32'h0000C005);
		rdc(`OFS_CONTROL, 32'h00004005, "broken unlock");
		chk(starts, 4, "no extra start");
		$display("test lock done");
		// reserved codes, then protected targets, then code zero clearing the flags
		run_op(4'h2, 1'b0, 0);
		run_op(4'h6, 1'b0, 0);
		run_op(4'hF, 1'b0, 0);
		prot <= 1'b1;
		run_op(4'h1, 1'b0, 0);
		rdc(`OFS_CONTROL, 32'h00006001, "fail on protect");
		prot <= 1'b0;
		aprot <= 1'b1;
		run_op(4'h5, 1'b0, 0);
		aprot <= 1'b0;
		run_op(4'h0, 1'b0, 0);
		rdc(`OFS_CONTROL, 32'h00004000, "flags cleared");
		$display("test codes done");
		// low voltage with detector on, then off
		low_voltage_detector <= 1'b1;
		repeat (3) @(posedge clk);
		rdc(`OFS_CONTROL, 32'h00005800, "low volt active");
		low_voltage_detector <= 1'b0;
		repeat (3) @(posedge clk);
		rdc(`OFS_CONTROL, 32'h00005000, "low volt ended");
		wr(`OFS_CONTROL, 32'h00000000);
		low_voltage_detector <= 1'b1;
		repeat (3) @(posedge clk);
		rdc(`OFS_CONTROL, 32'h00001000, "detector off");
		chk(det_en, 1'b0, "detector pin off");
		low_voltage_detector <= 1'b0;
		run_op(4'h0, 1'b0, 0);
		rdc(`OFS_CONTROL, 32'h00004000, "error cleared");
		$display("test low voltage done");
		// interrupt raise, mask, clear
		wr(`OFS_IRQ_CLR, 32'h00000007);
		wr(`OFS_IRQ_EN, 32'h00000001);
		chk(irq, 1'b0, "irq idle");
		run_op(4'h1, 1'b1, 1);
		chk(irq, 1'b1, "irq raised");
		rdc(`OFS_IRQ_STAT, 32'h00000001, "done status");
		wr(`OFS_IRQ_EN, 32'h00000000);
		chk(irq, 1'b0, "irq masked");
		wr(`OFS_IRQ_EN, 32'h00000001);
		chk(irq, 1'b1, "irq unmasked");
		wr(`OFS_IRQ_CLR, 32'h00000001);
		chk(irq, 1'b0, "irq cleared");
		$display("test interrupt done");
		// device reset keeps all control bits but write enable; power-on clears the rest
		rst_b <= 1'b0;
		@(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rdc(`OFS_CONTROL, 32'h00000001, "after device reset");
		rdc(`OFS_DATA, 32'hA5A5A5A5, "data kept");
		chk(f_wdata, 32'hA5A5A5A5, "word pin kept");
		por_b <= 1'b0;
		@(posedge clk);
		por_b <= 1'b1;
		@(posedge clk);
		rdc(`OFS_DATA, 32'h00000000, "data after power-on");
		$display("test resets done");
		final_report();
	end
endmodule
